// ---- lmc_params.svh ----
/*
  Constants for the link mode configuration block: register offsets, field
  positions, reset values and the fixed alignment-sequence field values.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef LMC_PARAMS_SVH
`define LMC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (word addresses on the plain register port)
// ----------------------------------------------------------------------
`define LMC_ADDR_W 4
`define LMC_REG_ENABLE 4'h0
`define LMC_REG_MODE 4'h1
`define LMC_REG_KM1 4'h2
`define LMC_REG_DID 4'h3
`define LMC_REG_CTRL 4'h4
`define LMC_REG_INMUX 4'h5
`define LMC_REG_CAL 4'h6
`define LMC_REG_STAT 4'h7
`define LMC_REG_PARAM0 4'h8
`define LMC_REG_PARAM1 4'h9
`define LMC_REG_ILAS_SEL 4'hA
`define LMC_REG_ILAS_DATA 4'hB

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define LMC_MODE_W 5
`define LMC_MODE_RST 5'h02
`define LMC_KM1_RST 8'h1F
`define LMC_DID_RST 8'h00
`define LMC_CTRL_SCR_BIT 0
`define LMC_INMUX_RST 2'h0
`define LMC_CAL_START_BIT 0
`define LMC_CAL_CYCLES 8'h10

// ----------------------------------------------------------------------
// Fixed alignment-sequence values
// ----------------------------------------------------------------------
`define LMC_JESDV 3'h1
`define LMC_SUBCLASSV 3'h1
`define LMC_E_FIXED 8'h01
`define LMC_ILAS_OCTETS 4'hE
`define LMC_CHK_IDX 4'hD

`endif

// ---- lmc_pkg.sv ----
/*
  Types for the link mode configuration block.
  Assumes lmc_params.svh is on the include path.
*/
`include "lmc_params.svh"

package lmc_pkg;

  typedef enum logic [1:0] {
    LMC_DUAL,
    LMC_SINGLE,
    LMC_DUAL_INPUT
  } lmc_op_e;

  typedef enum logic [1:0] {
    LMC_IN_FIRST,
    LMC_IN_SECOND,
    LMC_IN_BOTH,
    LMC_IN_RSVD
  } lmc_input_e;

  // Transport and link parameters as held, not yet minus-one encoded
  typedef struct packed {
    logic valid;
    logic interleave;
    logic enc_64b66b;
    logic [4:0] lanes;
    logic [4:0] octets;
    logic [4:0] converters;
    logic [4:0] resolution;
    logic [4:0] bits_per_sample;
    logic [4:0] samples;
    logic [1:0] control_bits;
    logic [1:0] links;
    logic [1:0] high_density;
    logic [7:0] rate_x8;
  } lmc_link_s;

  typedef struct packed {
    logic [`LMC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lmc_bus_s;

  typedef logic [7:0] lmc_octet_t;

endpackage : lmc_pkg

// ---- lmc_mode_rom.sv ----
/*
  Mode table: maps the link mode selection to transport and link parameters.
  The output is registered. Assumes lmc_pkg is compiled first.
*/
`timescale 1ns/100ps

`include "lmc_params.svh"

module lmc_mode_rom (
  input wire logic clk, // Device clock
  input wire logic ce, // Clock enable
  input wire logic rst, // Synchronous reset
  input wire logic [`LMC_MODE_W-1:0] mode, // Link mode selection
  output lmc_pkg::lmc_link_s link_q // Registered parameter set
);
  import lmc_pkg::*;

  lmc_link_s entry;

  // Fields: val int 64b L F M N N' S CS HD R*8
  function automatic lmc_link_s mk(input logic i, input logic [4:0] l, input logic [4:0] f,
      input logic [4:0] m, input logic [4:0] n, input logic [4:0] np, input logic [4:0] s,
      input logic [1:0] cs, input logic [1:0] hd, input logic [7:0] r8);
    lmc_link_s e;
    e = '0;
    e.valid = 1'b1;
    e.interleave = i;
    e.lanes = l;
    e.octets = f;
    e.converters = m;
    e.resolution = n;
    e.bits_per_sample = np;
    e.samples = s;
    e.control_bits = cs;
    e.links = 2'h2;
    e.high_density = hd;
    e.rate_x8 = r8;
    return e;
  endfunction : mk

  always_comb begin
    case (mode)
      5'h00: entry = mk(1'b1, 5'h04, 5'h08, 5'h04, 5'h0C, 5'h0C, 5'h05, 2'h0, 2'h0, 8'h20);
      5'h01: entry = mk(1'b1, 5'h08, 5'h08, 5'h08, 5'h0C, 5'h0C, 5'h05, 2'h0, 2'h0, 8'h10);
      5'h02: entry = mk(1'b0, 5'h04, 5'h08, 5'h04, 5'h0C, 5'h0C, 5'h05, 2'h0, 2'h0, 8'h20);
      5'h03: entry = mk(1'b0, 5'h08, 5'h08, 5'h08, 5'h0C, 5'h0C, 5'h05, 2'h0, 2'h0, 8'h10);
      5'h05: entry = mk(1'b1, 5'h04, 5'h01, 5'h01, 5'h08, 5'h08, 5'h04, 2'h0, 2'h0, 8'h14);
      5'h06: entry = mk(1'b1, 5'h08, 5'h01, 5'h01, 5'h08, 5'h08, 5'h08, 2'h0, 2'h0, 8'h0A);
      5'h07: entry = mk(1'b0, 5'h04, 5'h01, 5'h01, 5'h08, 5'h08, 5'h04, 2'h0, 2'h0, 8'h14);
      5'h08: entry = mk(1'b0, 5'h08, 5'h01, 5'h01, 5'h08, 5'h08, 5'h08, 2'h0, 2'h0, 8'h0A);
      5'h0A: entry = mk(1'b0, 5'h02, 5'h02, 5'h02, 5'h0F, 5'h10, 5'h01, 2'h1, 2'h0, 8'h28);
      5'h0B: entry = mk(1'b0, 5'h04, 5'h02, 5'h02, 5'h0F, 5'h10, 5'h02, 2'h1, 2'h0, 8'h14);
      5'h0C: entry = mk(1'b0, 5'h08, 5'h02, 5'h02, 5'h0F, 5'h10, 5'h04, 2'h1, 2'h0, 8'h0A);
      5'h0D: entry = mk(1'b0, 5'h01, 5'h04, 5'h02, 5'h0F, 5'h10, 5'h01, 2'h1, 2'h0, 8'h28);
      5'h0E: entry = mk(1'b0, 5'h02, 5'h02, 5'h02, 5'h0F, 5'h10, 5'h01, 2'h1, 2'h0, 8'h14);
      5'h0F: entry = mk(1'b0, 5'h04, 5'h02, 5'h02, 5'h0F, 5'h10, 5'h02, 2'h1, 2'h0, 8'h0A);
      5'h10: entry = mk(1'b0, 5'h08, 5'h02, 5'h02, 5'h0F, 5'h10, 5'h04, 2'h1, 2'h0, 8'h05);
      5'h13: entry = mk(1'b1, 5'h06, 5'h02, 5'h01, 5'h0C, 5'h0C, 5'h08, 2'h0, 2'h1, 8'h14);
      5'h14: entry = mk(1'b0, 5'h06, 5'h02, 5'h01, 5'h0C, 5'h0C, 5'h08, 2'h0, 2'h1, 8'h14);
      5'h15: entry = mk(1'b1, 5'h02, 5'h02, 5'h01, 5'h0F, 5'h10, 5'h02, 2'h1, 2'h0, 8'h28);
      5'h16: entry = mk(1'b1, 5'h04, 5'h02, 5'h01, 5'h0F, 5'h10, 5'h04, 2'h1, 2'h0, 8'h14);
      5'h17: entry = mk(1'b1, 5'h01, 5'h02, 5'h01, 5'h0F, 5'h10, 5'h01, 2'h1, 2'h0, 8'h28);
      5'h18: entry = mk(1'b1, 5'h02, 5'h02, 5'h01, 5'h0F, 5'h10, 5'h02, 2'h1, 2'h0, 8'h14);
      5'h19: entry = mk(1'b1, 5'h08, 5'h02, 5'h01, 5'h0F, 5'h10, 5'h08, 2'h1, 2'h0, 8'h0A);
      default: entry = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link_q <= '0;
    end else if (ce) begin
      link_q <= entry;
    end
  end

endmodule : lmc_mode_rom

// ---- lmc_link_config.sv ----
/*
  Link mode configuration and alignment-sequence parameter assembly for an
  interleaving dual-channel converter with a serial output link.
  Assumes a register master on the same clock with one-cycle strobes, and
  a calibration engine that reports completion on cal_done.
*/
`timescale 1ns/100ps

`include "lmc_params.svh"

module lmc_link_config #(
  parameter int CAL_CYCLES = 16 // Cycles the built-in calibration sequencer runs
) (
  input wire logic clk, // Device clock, 25 MHz
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic rst, // Synchronous reset, active high
  input lmc_pkg::lmc_bus_s bus, // Register port request
  input wire logic cal_done, // Calibration engine finished
  output logic [31:0] rdata_q, // Read data, one cycle after the read strobe
  output logic link_enable_q, // Serial link enable
  output logic link_reset_q, // Serial link held in reset
  output lmc_pkg::lmc_op_e op_mode_q, // Sampling operation
  output lmc_pkg::lmc_input_e input_sel_q, // Active analog input selection
  output logic interleave_q, // Interleave flag
  output logic pll_bypass_q, // Serializer PLL bypass
  output logic [7:0] pll_mult_x8_q, // Serializer PLL factor in eighths
  output logic sample_phase_q, // Channel phase: 1 for out of phase
  output logic [7:0] ilas_octet_q, // Alignment octet at the selected index
  output logic cal_request_q // Request to the calibration engine
);
  import lmc_pkg::*;

  // The count register is eight bits wide and must reach at least one
  if (CAL_CYCLES < 1 || CAL_CYCLES > 255) begin : g_cal_range
    $error("CAL_CYCLES out of range");
  end

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  wire logic wr_enable = bus.wr && (bus.addr == `LMC_REG_ENABLE);
  wire logic wr_mode = bus.wr && (bus.addr == `LMC_REG_MODE);
  wire logic wr_km1 = bus.wr && (bus.addr == `LMC_REG_KM1);
  wire logic wr_did = bus.wr && (bus.addr == `LMC_REG_DID);
  wire logic wr_ctrl = bus.wr && (bus.addr == `LMC_REG_CTRL);
  wire logic wr_inmux = bus.wr && (bus.addr == `LMC_REG_INMUX);
  wire logic wr_cal = bus.wr && (bus.addr == `LMC_REG_CAL);
  wire logic wr_ilas_sel = bus.wr && (bus.addr == `LMC_REG_ILAS_SEL);
  // Link parameters only accept writes while the link is disabled
  wire logic cfg_open = !link_enable_q;

  logic [`LMC_MODE_W-1:0] mode_q;
  logic [7:0] km1_q;
  logic [7:0] did_q;
  logic scr_q;
  logic [1:0] inmux_pend_q;
  logic [3:0] ilas_sel_q;
  logic mode_err_q;
  logic [7:0] cal_cnt_q;
  logic cal_busy_q;
  logic cal_done_s1_q;
  logic cal_done_s2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= `LMC_MODE_RST;
      km1_q <= `LMC_KM1_RST;
      did_q <= `LMC_DID_RST;
      scr_q <= 1'b0;
      link_enable_q <= 1'b0;
      inmux_pend_q <= `LMC_INMUX_RST;
      ilas_sel_q <= 4'h0;
    end else if (ce) begin
      if (wr_enable) link_enable_q <= bus.wdata[0];
      if (wr_mode && cfg_open) mode_q <= bus.wdata[`LMC_MODE_W-1:0];
      if (wr_km1 && cfg_open) km1_q <= bus.wdata[7:0];
      if (wr_did && cfg_open) did_q <= bus.wdata[7:0];
      if (wr_ctrl && cfg_open) scr_q <= bus.wdata[`LMC_CTRL_SCR_BIT];
      if (wr_inmux) inmux_pend_q <= bus.wdata[1:0];
      if (wr_ilas_sel) ilas_sel_q <= bus.wdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // Mode table
  // ----------------------------------------------------------------------
  lmc_link_s link;

  lmc_mode_rom u_rom (
    .clk(clk),
    .ce(ce),
    .rst(rst),
    .mode(mode_q),
    .link_q(link)
  );

  // ----------------------------------------------------------------------
  // Calibration: the input mux follows the pending selection only at the
  // end of a calibration, so a mid-run change never glitches sampling
  // ----------------------------------------------------------------------
  wire logic cal_start = wr_cal && bus.wdata[`LMC_CAL_START_BIT] && !cal_busy_q;
  wire logic cal_cnt_end = cal_busy_q && (cal_cnt_q == 8'h00);
  // External completion is asynchronous, so it is synchronised first
  wire logic cal_finish = cal_busy_q && (cal_cnt_end || cal_done_s2_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      cal_busy_q <= 1'b0;
      cal_cnt_q <= 8'h00;
      cal_request_q <= 1'b0;
      cal_done_s1_q <= 1'b0;
      cal_done_s2_q <= 1'b0;
      input_sel_q <= LMC_IN_FIRST;
    end else if (ce) begin
      cal_done_s1_q <= cal_done;
      cal_done_s2_q <= cal_done_s1_q;
      if (cal_start) begin
        cal_busy_q <= 1'b1;
        cal_cnt_q <= 8'(CAL_CYCLES - 1);
        cal_request_q <= 1'b1;
      end else if (cal_finish) begin
        cal_busy_q <= 1'b0;
        cal_request_q <= 1'b0;
        input_sel_q <= lmc_input_e'(inmux_pend_q);
      end else if (cal_busy_q) begin
        cal_cnt_q <= cal_cnt_q - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Operation and serializer derivation
  // ----------------------------------------------------------------------
  // Dual-input operation is a single-channel mode with both inputs selected
  wire logic sel_both = (input_sel_q == LMC_IN_BOTH);
  wire lmc_op_e op_d = !link.interleave ? LMC_DUAL :
      (sel_both ? LMC_DUAL_INPUT : LMC_SINGLE);
  wire logic bypass_d = (link.rate_x8 == 8'h08);

  always_ff @(posedge clk) begin
    if (rst) begin
      op_mode_q <= LMC_DUAL;
      interleave_q <= 1'b0;
      pll_bypass_q <= 1'b0;
      pll_mult_x8_q <= 8'h00;
      sample_phase_q <= 1'b0;
      link_reset_q <= 1'b1;
      mode_err_q <= 1'b0;
    end else if (ce) begin
      op_mode_q <= op_d;
      interleave_q <= link.interleave;
      pll_bypass_q <= bypass_d;
      pll_mult_x8_q <= link.rate_x8;
      sample_phase_q <= link.interleave;
      link_reset_q <= !link_enable_q || !link.valid;
      mode_err_q <= !link.valid;
    end
  end

  // ----------------------------------------------------------------------
  // Alignment-sequence octets, minus-one encoded where the format says so
  // ----------------------------------------------------------------------
  wire logic [7:0] f_m1 = {3'h0, link.octets - 5'h01};
  wire logic [7:0] l_m1 = {3'h0, link.lanes - 5'h01};
  wire logic [7:0] m_m1 = {3'h0, link.converters - 5'h01};
  wire logic [7:0] n_m1 = {3'h0, link.resolution - 5'h01};
  wire logic [7:0] np_m1 = {3'h0, link.bits_per_sample - 5'h01};
  wire logic [7:0] s_m1 = {3'h0, link.samples - 5'h01};
  // Frames per multiframe only matters in 8b10b; 64b66b would use E instead
  wire logic [7:0] k_fld = link.enc_64b66b ? 8'h00 : km1_q;
  wire logic [7:0] e_fld = link.enc_64b66b ? `LMC_E_FIXED : 8'h00;

  lmc_octet_t ilas [`LMC_ILAS_OCTETS];
  always_comb begin
    ilas[0] = did_q;
    ilas[1] = 8'h00;
    ilas[2] = 8'h00;
    ilas[3] = {scr_q, 7'h00};
    ilas[4] = l_m1;
    ilas[5] = f_m1;
    ilas[6] = k_fld;
    ilas[7] = m_m1;
    ilas[8] = n_m1; // CS sent zero in the top bits
    ilas[9] = {`LMC_SUBCLASSV, np_m1[4:0]};
    ilas[10] = {`LMC_JESDV, s_m1[4:0]};
    ilas[11] = 8'h00; // HD and CF zero
    ilas[12] = e_fld; // Reserved field reused for E in 64b66b only
    ilas[13] = 8'h00;
  end

  wire logic [7:0] chk_sum = 8'(
      {3'h0, did_q[7:0]} + {3'h0, 3'h0, l_m1[4:0]} + {3'h0, 3'h0, f_m1[4:0]} +
      {3'h0, k_fld} + {3'h0, 3'h0, m_m1[4:0]} + {3'h0, 3'h0, n_m1[4:0]} +
      {3'h0, 3'h0, np_m1[4:0]} + {3'h0, 3'h0, s_m1[4:0]} + {10'h000, scr_q} +
      {8'h00, `LMC_SUBCLASSV} + {8'h00, `LMC_JESDV});

  wire logic [7:0] ilas_pick = (ilas_sel_q == `LMC_CHK_IDX) ? chk_sum :
      (ilas_sel_q < `LMC_ILAS_OCTETS) ? ilas[ilas_sel_q] : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      ilas_octet_q <= 8'h00;
    end else if (ce) begin
      ilas_octet_q <= ilas_pick;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire logic [31:0] param0 = {link.octets, link.converters, link.lanes, link.samples,
      link.resolution, link.bits_per_sample, link.control_bits};
  wire logic [31:0] param1 = {8'h00, link.high_density, link.links, link.rate_x8,
      link.enc_64b66b, link.interleave, link.valid, e_fld[0], chk_sum};
  wire logic [31:0] stat = {25'h0, mode_err_q, link_reset_q, cal_busy_q,
      2'(input_sel_q), 2'(op_mode_q)};

  logic [31:0] rd_mux;
  always_comb begin
    case (bus.addr)
      `LMC_REG_ENABLE: rd_mux = {31'h0, link_enable_q};
      `LMC_REG_MODE: rd_mux = {27'h0, mode_q};
      `LMC_REG_KM1: rd_mux = {24'h0, km1_q};
      `LMC_REG_DID: rd_mux = {24'h0, did_q};
      `LMC_REG_CTRL: rd_mux = {31'h0, scr_q};
      `LMC_REG_INMUX: rd_mux = {30'h0, inmux_pend_q};
      `LMC_REG_CAL: rd_mux = {31'h0, cal_busy_q};
      `LMC_REG_STAT: rd_mux = stat;
      `LMC_REG_PARAM0: rd_mux = param0;
      `LMC_REG_PARAM1: rd_mux = param1;
      `LMC_REG_ILAS_SEL: rd_mux = {28'h0, ilas_sel_q};
      `LMC_REG_ILAS_DATA: rd_mux = {24'h0, ilas_pick};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (ce) begin
      rdata_q <= bus.rd ? rd_mux : 32'h0;
    end
  end

endmodule : lmc_link_config

// ---- lmc_link_config_sva.sv ----
/*
  Checker for the link mode configuration block: relations between its ports.
  Assumes it is bound to lmc_link_config and that lmc_params.svh is reachable.
*/
`timescale 1ns/100ps
`include "lmc_params.svh"

module lmc_link_config_sva
  import lmc_pkg::*;
#(
  parameter int CAL_CYCLES = 16 // Calibration sequencer length
) (
  input wire logic clk, // Device clock
  input wire logic ce, // Clock enable
  input wire logic rst, // Synchronous reset
  input lmc_pkg::lmc_bus_s bus, // Register port request
  input wire logic cal_request_q, // Calibration running
  input wire logic link_enable_q, // Serial link enable
  input wire logic link_reset_q, // Serial link held in reset
  input lmc_pkg::lmc_op_e op_mode_q, // Sampling operation
  input lmc_pkg::lmc_input_e input_sel_q, // Applied input selection
  input wire logic interleave_q, // Interleave flag
  input wire logic pll_bypass_q, // Serializer PLL bypass
  input wire logic [7:0] pll_mult_x8_q, // PLL factor in eighths
  input wire logic sample_phase_q // Out-of-phase sampling
);
  // Done may end the run early, so only the upper bound is fixed
  localparam int CAL_MAX = CAL_CYCLES + 3;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Mode-derived outputs
  // ----------------------------------------------------------------------
  property p_interleave_set;
    op_mode_q != LMC_DUAL |-> interleave_q;
  endproperty
  a_interleave_set: assert property (p_interleave_set)
    else $error("interleave flag low in an interleaved mode");

  property p_dual_plain;
    op_mode_q == LMC_DUAL |-> !interleave_q && !sample_phase_q;
  endproperty
  a_dual_plain: assert property (p_dual_plain)
    else $error("dual-channel mode shows interleave or phase offset");

  property p_dual_input_phase;
    op_mode_q == LMC_DUAL_INPUT |-> sample_phase_q;
  endproperty
  a_dual_input_phase: assert property (p_dual_input_phase)
    else $error("dual-input mode not sampling out of phase");

  property p_bypass;
    pll_bypass_q == (pll_mult_x8_q == 8'h08);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("PLL bypass disagrees with rate factor");

  // ----------------------------------------------------------------------
  // Link enable
  // ----------------------------------------------------------------------
  property p_reset_while_off;
    !link_enable_q [*3] |-> link_reset_q;
  endproperty
  a_reset_while_off: assert property (p_reset_while_off)
    else $error("link out of reset while disabled");

  property p_frozen_while_on;
    link_enable_q [*4] |-> $stable(pll_mult_x8_q) && $stable(interleave_q);
  endproperty
  a_frozen_while_on: assert property (p_frozen_while_on)
    else $error("link parameters changed while link enabled");

  // ----------------------------------------------------------------------
  // Calibration and input selection
  // ----------------------------------------------------------------------
  property p_cal_start;
    ce && bus.wr && bus.addr == `LMC_REG_CAL && bus.wdata[0] && !cal_request_q
      |=> cal_request_q;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration did not start");

  property p_cal_bound;
    $rose(cal_request_q) |-> ##[1:CAL_MAX] !cal_request_q;
  endproperty
  a_cal_bound: assert property (p_cal_bound)
    else $error("calibration ran too long");

  property p_insel_at_cal_end;
    $changed(input_sel_q) |-> $fell(cal_request_q);
  endproperty
  a_insel_at_cal_end: assert property (p_insel_at_cal_end)
    else $error("input selection changed outside calibration end");

endmodule : lmc_link_config_sva

// ---- lmc_cal_engine.sv ----
/*
  Behavioural calibration engine that answers the block's calibration request.
  Assumes the block's clock and a completion delay chosen by the testbench.
*/
`timescale 1ns/100ps

module lmc_cal_engine (
  input wire logic clk, // Device clock
  input wire logic rst, // Synchronous reset
  input wire logic cal_req, // Calibration requested
  input wire logic [4:0] delay, // Cycles before done is reported
  output logic cal_done // Calibration finished, level
);
  logic [4:0] cnt_q;

  // Done only stands while requested, yet through the two-stage synchroniser a stale done can end a run started one or two cycles after the last
  always_ff @(posedge clk) begin
    if (rst || !cal_req) begin
      cnt_q <= 5'h00;
      cal_done <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
      cal_done <= (cnt_q >= delay);
    end
  end
endmodule : lmc_cal_engine

// ---- lmc_link_config_tb.sv ----
/*
  Self-checking testbench for lmc_link_config: modes, alignment octets,
  link enable refusal and calibration. Assumes the checker and engine model.
*/
`timescale 1ns/100ps
`include "lmc_params.svh"

module lmc_link_config_tb;
  import lmc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  lmc_bus_s bus = '0;
  logic cal_done;
  logic [4:0] cal_delay = 5'h00;
  logic [31:0] rdata_q;
  logic link_enable_q, link_reset_q, interleave_q, pll_bypass_q, sample_phase_q, cal_request_q;
  lmc_op_e op_mode_q;
  lmc_input_e input_sel_q;
  logic [7:0] pll_mult_x8_q, ilas_octet_q, did, km1;
  logic scr;
  logic [31:0] v;
  int n_fail = 0;
  int n_checks = 0;
  int seed;
  // Mode, interleave, L, M, F, S, N, N', rate in eighths
  int tab [6][9] = '{'{0, 1, 4, 4, 8, 5, 12, 12, 32}, '{2, 0, 4, 4, 8, 5, 12, 12, 32},
    '{5, 1, 4, 1, 1, 4, 8, 8, 20}, '{10, 0, 2, 2, 2, 1, 15, 16, 40},
    '{19, 1, 6, 1, 2, 8, 12, 12, 20}, '{16, 0, 8, 2, 2, 4, 15, 16, 5}};

  lmc_link_config #(.CAL_CYCLES(8)) lmc_link_config_inst (.clk(clk), .ce(ce), .rst(rst),
    .bus(bus), .cal_done(cal_done), .rdata_q(rdata_q), .link_enable_q(link_enable_q),
    .link_reset_q(link_reset_q), .op_mode_q(op_mode_q), .input_sel_q(input_sel_q),
    .interleave_q(interleave_q), .pll_bypass_q(pll_bypass_q), .pll_mult_x8_q(pll_mult_x8_q),
    .sample_phase_q(sample_phase_q), .ilas_octet_q(ilas_octet_q),
    .cal_request_q(cal_request_q));
  lmc_cal_engine lmc_cal_engine_inst (.clk(clk), .rst(rst), .cal_req(cal_request_q),
    .delay(cal_delay), .cal_done(cal_done));

  initial begin
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata_q;
  endtask : rd

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------------
  function automatic logic [7:0] oct(int r, int i);
    case (i)
      0: return did;
      3: return {scr, 7'h00};
      4: return 8'(tab[r][2] - 1);
      5: return 8'(tab[r][4] - 1);
      6: return km1;
      7: return 8'(tab[r][3] - 1);
      8: return 8'(tab[r][6] - 1);
      9: return 8'h20 | 8'(tab[r][7] - 1);
      10: return 8'h20 | 8'(tab[r][5] - 1);
      // Field values summed: six minus-one fields, plus one each for the two version fields
      13: return 8'(did + km1 + scr + tab[r][2] + tab[r][4] + tab[r][3] + tab[r][6] +
          tab[r][7] + tab[r][5] - 4);
      default: return 8'h00;
    endcase
  endfunction : oct

  task automatic setup(int r);
    did = 8'($urandom);
    km1 = 8'hFF - 8'(16 * ($urandom % 8));
    scr = 1'($urandom);
    wr(`LMC_REG_MODE, 32'(tab[r][0]));
    wr(`LMC_REG_KM1, {24'h0, km1});
    wr(`LMC_REG_DID, {24'h0, did});
    wr(`LMC_REG_CTRL, {31'h0, scr});
  endtask : setup

  task automatic derived(int r, lmc_op_e op);
    tick(4);
    chk("interleave", 32'(tab[r][1]), 32'(interleave_q));
    chk("op_mode", 32'(op), 32'(op_mode_q));
    chk("pll_mult", 32'(tab[r][8]), 32'(pll_mult_x8_q));
    chk("pll_bypass", 32'h0, 32'(pll_bypass_q));
    chk("phase_mode", 32'(tab[r][1]), 32'(sample_phase_q));
  endtask : derived

  task automatic ilas_all(int r);
    logic [7:0] e;
    for (int i = 0; i < 14; i++) begin
      e = oct(r, i);
      wr(`LMC_REG_ILAS_SEL, 32'(i));
      rd(`LMC_REG_ILAS_DATA, v);
      chk("ilas_data", {24'h0, e}, {24'h0, v[7:0]});
      chk("ilas_octet", {24'h0, e}, {24'h0, ilas_octet_q});
    end
  endtask : ilas_all

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = $urandom(83143);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tick(3);
    chk("reset_link", 32'h1, 32'(link_reset_q));
    derived(1, LMC_DUAL);
    for (int r = 0; r < 6; r++) begin
      wr(`LMC_REG_ENABLE, 32'h0);
      setup(r);
      derived(r, tab[r][1] ? LMC_SINGLE : LMC_DUAL);
      ilas_all(r);
      wr(`LMC_REG_ENABLE, 32'h1);
      tick(3);
      chk("link_reset_on", 32'h0, 32'(link_reset_q));
    end
    wr(`LMC_REG_MODE, 32'h0);
    wr(`LMC_REG_KM1, {24'h0, ~km1});
    derived(5, LMC_DUAL);
    ilas_all(5);
    rd(4'hF, v);
    chk("unmapped", 32'h0, v);
    wr(`LMC_REG_ENABLE, 32'h0);
    wr(`LMC_REG_MODE, 32'h4);
    tick(4);
    wr(`LMC_REG_ENABLE, 32'h1);
    tick(3);
    chk("reserved_mode", 32'h1, 32'(link_reset_q));
    rd(`LMC_REG_STAT, v);
    chk("stat_err", 32'h3, {30'h0, v[6:5]});
    wr(`LMC_REG_ENABLE, 32'h0);
    setup(0);
    derived(0, LMC_SINGLE);
    foreach (tab[k]) begin
      logic [1:0] sel;
      logic [1:0] prev;
      int n;
      sel = 2'((k + 1) % 3);
      prev = input_sel_q;
      wr(`LMC_REG_INMUX, {30'h0, sel});
      tick(3);
      chk("insel_pending", {30'h0, prev}, 32'(input_sel_q));
      @(posedge clk);
      cal_delay <= 5'($urandom % 20);
      wr(`LMC_REG_CAL, 32'h1);
      #1;
      chk("cal_req", 32'h1, 32'(cal_request_q));
      for (n = 0; n < 40 && cal_request_q !== 1'b0; n++) tick(1);
      tick(3);
      chk("cal_end", 32'h0, 32'(cal_request_q));
      chk("insel", {30'h0, sel}, 32'(input_sel_q));
      derived(0, sel == 2'h2 ? LMC_DUAL_INPUT : LMC_SINGLE);
      // Interleaved modes run the two channels out of phase whatever input feeds them
      chk("phase", 32'h1, 32'(sample_phase_q));
      if (sel == 2'h2) ilas_all(0);
    end
    // With the clock enable low a write must not reach the link enable
    @(posedge clk);
    ce <= 1'b0;
    wr(`LMC_REG_ENABLE, 32'h1);
    tick(3);
    chk("ce_freeze", 32'h1, 32'(link_reset_q));
    @(posedge clk);
    ce <= 1'b1;
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule : lmc_link_config_tb

bind lmc_link_config lmc_link_config_sva #(.CAL_CYCLES(CAL_CYCLES)) lmc_link_config_sva_inst (
  .clk(clk), .ce(ce), .rst(rst), .bus(bus), .cal_request_q(cal_request_q),
  .link_enable_q(link_enable_q), .link_reset_q(link_reset_q), .op_mode_q(op_mode_q),
  .input_sel_q(input_sel_q), .interleave_q(interleave_q), .pll_bypass_q(pll_bypass_q),
  .pll_mult_x8_q(pll_mult_x8_q), .sample_phase_q(sample_phase_q));
